/* File: core/esb_dev.sv */
// Memory end of the link: select decode, acknowledge, array, programming
`timescale 1ns/1ps
`default_nettype none

// ======================================================
// Memory slave
module esb_dev (
  // Link
  esb_if.dev               bus,
  // System clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Straps
  input  wire logic        chip_sel_pin_0,
  input  wire logic        chip_sel_pin_1,
  input  wire logic        chip_sel_pin_2,
  input  wire logic        write_protect_input,
  // Status
  output logic             prog_busy,
  output logic [7:0]       prog_count
);
  logic [7:0] mem [2**esb_pkg::ADDR_W];

  // ======================================================
  // Serial clock domain: pin synchronisers
  logic       rs1, rs2, wp1, wp2;
  logic [2:0] cs1, cs2;

  always_ff @(posedge bus.scl) begin
    rs1 <= rst;
    rs2 <= rs1;
    cs1 <= {chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0};
    cs2 <= cs1;
    wp1 <= write_protect_input;
    wp2 <= wp1;
  end

  // ======================================================
  // Start and stop detectors, clocked by data edges
  logic start_tgl, stop_tgl, next_start_tgl, next_stop_tgl;

  always_comb begin
    next_start_tgl = bus.scl ? ~start_tgl : start_tgl;
    next_stop_tgl  = bus.scl ? ~stop_tgl : stop_tgl;
  end

  always_ff @(negedge bus.sda) begin
    if (rs2) begin
      start_tgl <= 1'b0;
    end else begin
      start_tgl <= next_start_tgl;
    end
  end

  always_ff @(posedge bus.sda) begin
    if (rs2) begin
      stop_tgl <= 1'b0;
    end else begin
      stop_tgl <= next_stop_tgl;
    end
  end

  // ======================================================
  // Byte engine on rising serial clock
  esb_pkg::esb_link_st_t st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  sh, next_sh, tx, next_tx, byte_in;
  logic [15:0] addr, next_addr;
  logic        ack, next_ack, rw, next_rw, req_tgl, next_req_tgl;
  logic        start_seen, next_start_seen, stop_seen, next_stop_seen;
  logic [2:0]  cred, next_cred;
  logic [esb_pkg::FIFO_W-1:0] wbuf, next_wbuf;

  always_comb begin
    byte_in         = {sh[6:0], bus.sda};
    next_st         = st;
    next_cnt        = cnt;
    next_sh         = sh;
    next_tx         = tx;
    next_addr       = addr;
    next_ack        = ack;
    next_rw         = rw;
    next_req_tgl    = req_tgl;
    next_wbuf       = wbuf;
    next_start_seen = start_seen;
    next_stop_seen  = stop_seen;
    next_cred       = cred;
    if (start_tgl != start_seen) begin
      next_start_seen = start_tgl;
      next_stop_seen  = stop_tgl;
      next_st         = esb_pkg::LS_SEL;
      next_sh         = {7'h00, bus.sda};
      next_cnt        = 4'h1;
      next_ack        = 1'b0;
      next_cred       = 3'h0;
    end else if (stop_tgl != stop_seen) begin
      next_stop_seen = stop_tgl;
      next_st        = esb_pkg::LS_IDLE;
      next_ack       = 1'b0;
    end else if (st != esb_pkg::LS_IDLE && st != esb_pkg::LS_IGNORE) begin
      if (cnt < esb_pkg::LAST_BIT) begin
        next_sh  = byte_in;
        next_cnt = cnt + 4'h1;
      end else if (cnt == esb_pkg::LAST_BIT) begin
        next_sh  = byte_in;
        next_cnt = esb_pkg::ACK_SLOT;
        case (st)
          esb_pkg::LS_SEL: begin
            if (byte_in[7:4] == esb_pkg::DEV_TYPE
                && byte_in[3:1] == cs2) begin
              next_ack = 1'b1;
              next_rw  = byte_in[0];
            end else begin
              next_st = esb_pkg::LS_IGNORE;
            end
          end
          esb_pkg::LS_ADDR_HI: begin
            next_addr[15:8] = byte_in;
            next_ack        = 1'b1;
          end
          esb_pkg::LS_ADDR_LO: begin
            next_addr[7:0] = byte_in;
            next_ack       = 1'b1;
          end
          esb_pkg::LS_WRITE: begin
            if (!wp2 && cred != esb_pkg::CRED_FULL) begin
              next_ack     = 1'b1;
              next_wbuf    = {addr, byte_in};
              next_req_tgl = ~req_tgl;
              next_addr    = addr + 16'h0001;
              next_cred    = cred + 3'h1;
            end
          end
          default: next_ack = 1'b0;
        endcase
      end else begin
        next_cnt = 4'h0;
        next_ack = 1'b0;
        case (st)
          esb_pkg::LS_SEL: begin
            next_st = rw ? esb_pkg::LS_READ : esb_pkg::LS_ADDR_HI;
            next_tx = mem[addr];
          end
          esb_pkg::LS_ADDR_HI: next_st = esb_pkg::LS_ADDR_LO;
          esb_pkg::LS_ADDR_LO: next_st = esb_pkg::LS_WRITE;
          esb_pkg::LS_READ: begin
            next_addr = addr + 16'h0001;
            next_tx   = mem[next_addr];
            if (bus.sda) begin
              next_st = esb_pkg::LS_IGNORE;
            end
          end
          default: next_st = st;
        endcase
      end
    end
  end

  always_ff @(posedge bus.scl) begin
    if (rs2) begin
      st         <= esb_pkg::LS_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      tx         <= 8'hFF;
      addr       <= esb_pkg::ADDR_RST;
      ack        <= 1'b0;
      rw         <= 1'b0;
      req_tgl    <= 1'b0;
      wbuf       <= '0;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
      cred       <= 3'h0;
    end else begin
      st         <= next_st;
      cnt        <= next_cnt;
      sh         <= next_sh;
      tx         <= next_tx;
      addr       <= next_addr;
      ack        <= next_ack;
      rw         <= next_rw;
      req_tgl    <= next_req_tgl;
      wbuf       <= next_wbuf;
      start_seen <= next_start_seen;
      stop_seen  <= next_stop_seen;
      cred       <= next_cred;
    end
  end

  // ======================================================
  // Data line driver, changes on falling serial clock
  logic oe, next_oe;

  always_comb begin
    if (cnt == esb_pkg::ACK_SLOT) begin
      next_oe = ack;
    end else if (st == esb_pkg::LS_READ) begin
      next_oe = ~tx[~cnt[2:0]];
    end else begin
      next_oe = 1'b0;
    end
  end

  always_ff @(negedge bus.scl) begin
    if (rs2) begin
      oe <= 1'b0;
    end else begin
      oe <= next_oe;
    end
  end

  assign bus.dev_sda_oe  = oe;
  assign bus.dev_sda_out = 1'b0;

  // ======================================================
  // System domain: buffering and array programming
  logic rq1, rq2, rq3, sp1, sp2, sp3;
  logic pend, next_pend, next_busy;
  logic f_ready, f_valid;
  logic [esb_pkg::FIFO_W-1:0] f_data;
  logic [7:0] next_count;

  esb_fifo #(.W(esb_pkg::FIFO_W), .D(esb_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (pend),
    .in_ready  (f_ready),
    .in_data   (wbuf),
    .out_valid (f_valid),
    .out_ready (prog_busy),
    .out_data  (f_data)
  );

  always_comb begin
    next_pend  = (rq3 ^ rq2) | (pend & ~f_ready);
    next_busy  = (sp3 ^ sp2) | (prog_busy & f_valid);
    next_count = (prog_busy & f_valid) ? prog_count + 8'h01 : prog_count;
  end

  always_ff @(posedge ref_clk) begin
    rq1 <= req_tgl;
    rq2 <= rq1;
    rq3 <= rq2;
    sp1 <= stop_tgl;
    sp2 <= sp1;
    sp3 <= sp2;
    if (rst) begin
      pend       <= 1'b0;
      prog_busy  <= 1'b0;
      prog_count <= 8'h00;
    end else begin
      pend       <= next_pend;
      prog_busy  <= next_busy;
      prog_count <= next_count;
    end
    if (prog_busy && f_valid) begin
      mem[f_data[esb_pkg::FIFO_W-1:8]] <= f_data[7:0];
    end
  end
endmodule
`default_nettype wire

/* File: core/esb_host.sv */
// Master end of the link, and the write buffer used by the memory end
`timescale 1ns/1ps
`default_nettype none

// ======================================================
// Write buffer
module esb_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0] buf_q [D];
  logic [PW-1:0] wp, rp, next_wp, next_rp;
  logic [PW:0]   cnt, next_cnt;
  logic          push, pop;

  always_comb begin
    in_ready  = cnt != (PW+1)'(D);
    out_valid = cnt != '0;
    out_data  = buf_q[rp];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    next_wp   = push ? PW'(wp + 1'b1) : wp;
    next_rp   = pop ? PW'(rp + 1'b1) : rp;
    next_cnt  = (PW+1)'(cnt + push - pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
    if (push) begin
      buf_q[wp] <= in_data;
    end
  end
endmodule

// ======================================================
// Bus master
module esb_host (
  // Link
  esb_if.host              bus,
  // System clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_nack,
  // Response
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_nack
);
  esb_pkg::esb_host_st_t st, next_st;
  esb_pkg::esb_op_t      op, next_op;
  logic [6:0] qcnt, next_qcnt;
  logic [1:0] ph, next_ph;
  logic [3:0] bi, next_bi;
  logic [7:0] wb, next_wb, next_rdata;
  logic       nk, next_nk, clr, next_clr;
  logic       scl_o, next_scl, oe, next_oe;
  logic       next_rvalid, next_rnack;
  logic       s1, s2, tick, last;

  // ======================================================
  // Command engine, four phases per bit
  always_comb begin
    cmd_ready   = st == esb_pkg::HS_IDLE;
    tick        = qcnt == esb_pkg::QTR_LAST;
    last        = op == esb_pkg::OP_START || op == esb_pkg::OP_STOP
                  || bi == esb_pkg::ACK_SLOT;
    next_st     = st;
    next_op     = op;
    next_qcnt   = tick ? 7'h00 : qcnt + 7'h01;
    next_ph     = ph;
    next_bi     = bi;
    next_wb     = wb;
    next_nk     = nk;
    next_clr    = clr;
    next_scl    = scl_o;
    next_oe     = oe;
    next_rdata  = rsp_data;
    next_rnack  = rsp_nack;
    next_rvalid = 1'b0;
    if (st == esb_pkg::HS_IDLE) begin
      next_qcnt = 7'h00;
      if (cmd_valid) begin
        next_st = esb_pkg::HS_RUN;
        next_op = esb_pkg::esb_op_t'(cmd_op);
        next_wb = cmd_data;
        next_nk = cmd_nack;
        next_ph = 2'h0;
        next_bi = 4'h0;
      end
    end else if (tick) begin
      next_ph = ph + 2'h1;
      case (ph)
        2'h0: next_scl = 1'b0;
        2'h1: begin
          case (op)
            esb_pkg::OP_START: next_oe = 1'b0;
            esb_pkg::OP_STOP:  next_oe = 1'b1;
            esb_pkg::OP_WRITE:
              next_oe = (bi < esb_pkg::ACK_SLOT) & ~wb[~bi[2:0]];
            default: next_oe = (bi == esb_pkg::ACK_SLOT) & ~nk;
          endcase
          next_scl = 1'b0;
        end
        2'h2: next_scl = 1'b1;
        default: begin
          if (op == esb_pkg::OP_START) begin
            next_oe = 1'b1;
          end else if (op == esb_pkg::OP_STOP) begin
            next_oe = 1'b0;
          end else if (bi < esb_pkg::ACK_SLOT) begin
            next_rdata = {rsp_data[6:0], s2};
          end else begin
            next_rnack = s2;
          end
          next_bi = bi + 4'h1;
          if (last) begin
            if (clr && op == esb_pkg::OP_READ) begin
              next_op = esb_pkg::OP_STOP;
              next_bi = 4'h0;
            end else begin
              next_clr    = 1'b0;
              next_st     = esb_pkg::HS_IDLE;
              next_rvalid = ~clr;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    s1 <= bus.sda;
    s2 <= s1;
    if (rst) begin
      // Bus clear: nine released clocks, then a stop
      st        <= esb_pkg::HS_RUN;
      op        <= esb_pkg::OP_READ;
      qcnt      <= 7'h00;
      ph        <= 2'h0;
      bi        <= 4'h0;
      wb        <= 8'hFF;
      nk        <= 1'b1;
      clr       <= 1'b1;
      scl_o     <= 1'b1;
      oe        <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b1;
    end else begin
      st        <= next_st;
      op        <= next_op;
      qcnt      <= next_qcnt;
      ph        <= next_ph;
      bi        <= next_bi;
      wb        <= next_wb;
      nk        <= next_nk;
      clr       <= next_clr;
      scl_o     <= next_scl;
      oe        <= next_oe;
      rsp_valid <= next_rvalid;
      rsp_data  <= next_rdata;
      rsp_nack  <= next_rnack;
    end
  end

  assign bus.scl          = scl_o;
  assign bus.host_sda_oe  = oe;
  assign bus.host_sda_out = 1'b0;
endmodule
`default_nettype wire

/* File: core/esb_if.sv */
// Two-wire link between the bus master and the memory slave
`timescale 1ns/1ps
`default_nettype none
interface esb_if;
  logic scl;
  logic host_sda_oe;
  logic host_sda_out;
  logic dev_sda_oe;
  logic dev_sda_out;
  logic sda;
  // Open-drain wire with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_oe, output dev_sda_out);
  modport host (output scl, output host_sda_oe, output host_sda_out,
                input sda);
endinterface
`default_nettype wire

/* File: core/esb_pkg.sv */
// Constants and types shared by both ends of the serial memory bus
package esb_pkg;
  localparam int ADDR_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = ADDR_W + 8;
  // Device type code, value arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [2:0] CRED_FULL = 3'(FIFO_DEPTH);
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  typedef enum logic [2:0] {
    LS_IDLE, LS_SEL, LS_ADDR_HI, LS_ADDR_LO, LS_WRITE, LS_READ, LS_IGNORE
  } esb_link_st_t;
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} esb_op_t;
  typedef enum logic [1:0] {HS_IDLE, HS_RUN} esb_host_st_t;
endpackage

/* File: testbench/esb_assertions.sv */
// Link checks for the serial memory bus, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module esb_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  // Straps and status
  input wire logic chip_sel_pin_0,
  input wire logic chip_sel_pin_1,
  input wire logic chip_sel_pin_2,
  input wire logic write_protect_input,
  input wire logic prog_busy
);
  // ======================================================
  // Link tracker
  logic       scl_q, sda_q, frame, sel, rd;
  logic       next_frame, next_sel, next_rd;
  logic [3:0] bitn, bcnt, since;
  logic [3:0] next_bitn, next_bcnt, next_since;
  logic [6:0] shreg, next_shreg;
  logic       rise, start_ev, stop_ev, ack_pt, hit;
  always_comb begin
    rise = scl & ~scl_q;
    start_ev = scl & scl_q & sda_q & ~sda;
    stop_ev = scl & scl_q & ~sda_q & sda;
    ack_pt = rise & (bitn == 4'h8);
    hit = (shreg[6:3] == esb_pkg::DEV_TYPE) &&
      (shreg[2:0] == {chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0});
    next_frame = frame;
    next_sel = sel;
    next_rd = rd;
    next_bitn = bitn;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_since = (since == 4'hF) ? since : since + 4'h1;
    if (rise) begin
      next_bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn != 4'h8) next_shreg = {shreg[5:0], sda};
      if (bitn == 4'h8 && bcnt != 4'hF) next_bcnt = bcnt + 4'h1;
      if (bitn == 4'h7 && bcnt == 4'h0) begin
        next_sel = hit;
        next_rd = sda;
      end
    end
    if (start_ev) begin
      next_frame = 1'b1;
      next_bitn = 4'h0;
      next_bcnt = 4'h0;
      next_sel = 1'b0;
    end
    if (stop_ev) begin
      next_frame = 1'b0;
      next_since = 4'h0;
    end
  end
  always_ff @(posedge ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    frame <= rst ? 1'b0 : next_frame;
    sel <= rst ? 1'b0 : next_sel;
    rd <= rst ? 1'b0 : next_rd;
    bitn <= rst ? 4'h0 : next_bitn;
    bcnt <= rst ? 4'h0 : next_bcnt;
    shreg <= rst ? 7'h00 : next_shreg;
    since <= rst ? 4'hF : next_since;
  end
  // ======================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_IDLE_SILENT: assert property (!frame |-> !dev_sda_oe)
    else $error("memory drives data outside a transfer");
  AST_SEL_ACK: assert property (
    ack_pt && bcnt == 4'h0 |-> dev_sda_oe == sel)
    else $error("select acknowledge wrong");
  AST_ADDR_ACK: assert property (
    ack_pt && sel && !rd && bcnt inside {4'h1, 4'h2} |-> dev_sda_oe)
    else $error("address byte not acknowledged");
  AST_DATA_ACK: assert property (
    ack_pt && sel && !rd && bcnt >= 4'h3
    |-> dev_sda_oe == (!write_protect_input && bcnt < 4'h7))
    else $error("data acknowledge wrong");
  AST_READ_RELEASE: assert property (
    ack_pt && sel && rd && bcnt != 4'h0 |-> !dev_sda_oe)
    else $error("memory holds data in read acknowledge slot");
  AST_MISS_SILENT: assert property (
    frame && !sel && bcnt != 4'h0 |-> !dev_sda_oe)
    else $error("unselected memory drives data");
  AST_DEV_CHG_LOW: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("memory changes data while clock high");
  AST_HOST_CHG_LOW: assert property (
    $changed(host_sda_oe) && scl |-> start_ev || stop_ev)
    else $error("master changes data while clock high");
  AST_PROG_AFTER_STOP: assert property (
    $rose(prog_busy) |-> since < 4'h8)
    else $error("programming starts without a stop");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench joining the master and memory ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst, dev_rst, cmd_valid, cmd_nack, wp;
  logic        cmd_ready, rsp_valid, rsp_nack, prog_busy;
  logic [1:0]  cmd_op;
  logic [7:0]  cmd_data, rsp_data, prog_count;
  logic [2:0]  pins;
  logic [15:0] addr;
  logic [7:0]  mem [logic [15:0]];
  int          mismatches, checks, seed;
  esb_if i_esb_if ();
  esb_host i_esb_host (.bus(i_esb_if), .ref_clk(ref_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  esb_dev i_esb_dev (.bus(i_esb_if), .ref_clk(ref_clk), .rst(dev_rst),
    .chip_sel_pin_0(pins[0]), .chip_sel_pin_1(pins[1]),
    .chip_sel_pin_2(pins[2]), .write_protect_input(wp),
    .prog_busy(prog_busy), .prog_count(prog_count));
  esb_assertions i_esb_assertions (.ref_clk(ref_clk), .rst(dev_rst),
    .scl(i_esb_if.scl), .sda(i_esb_if.sda),
    .host_sda_oe(i_esb_if.host_sda_oe), .dev_sda_oe(i_esb_if.dev_sda_oe),
    .chip_sel_pin_0(pins[0]), .chip_sel_pin_1(pins[1]),
    .chip_sel_pin_2(pins[2]), .write_protect_input(wp),
    .prog_busy(prog_busy));
  // ======================================================
  // Checks and verdict
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0b seen %0b", what, e, g);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bounded wait at falling edges for command ready or a response
  task automatic wait_flag(input bit on_rsp);
    int n;
    n = 0;
    while ((on_rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 40000) begin
        mismatches++;
        print_verdict();
      end
    end
  endtask
  // ======================================================
  // Expectations
  function automatic logic [7:0] sel_byte(logic [2:0] p, logic r);
    return {esb_pkg::DEV_TYPE, p, r};
  endfunction
  function automatic logic exp_ack(int idx, logic p);
    return !p && idx < esb_pkg::FIFO_DEPTH;
  endfunction
  // ======================================================
  // Command port
  task automatic cmd(input esb_pkg::esb_op_t op, input logic [7:0] d,
                     input logic nk);
    wait_flag(1'b0);
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_flag(1'b1);
  endtask
  task automatic wr(input logic [7:0] d, input logic ack);
    cmd(esb_pkg::OP_WRITE, d, 1'b0);
    chk_bit("write ack", !ack, rsp_nack);
  endtask
  task automatic set_addr(input logic [15:0] a);
    cmd(esb_pkg::OP_START, 8'h00, 1'b0);
    wr(sel_byte(pins, 1'b0), 1'b1);
    wr(a[15:8], 1'b1);
    wr(a[7:0], 1'b1);
  endtask
  task automatic do_write(input logic [15:0] a, input int n, input logic p);
    logic [7:0] d;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      wr(d, exp_ack(i, p));
      if (exp_ack(i, p)) mem[a + 16'(i)] = d;
    end
    cmd(esb_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic do_read(input logic [15:0] a, input int n);
    set_addr(a);
    cmd(esb_pkg::OP_START, 8'h00, 1'b0);
    wr(sel_byte(pins, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      cmd(esb_pkg::OP_READ, 8'h00, i == n - 1);
      chk_byte("read data", mem[a + 16'(i)], rsp_data);
    end
    cmd(esb_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  // ======================================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #(esb_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  initial begin
    seed = 32'h81CE;
    mismatches = 0;
    checks = 0;
    rst = 1'b1;
    dev_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_nack = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    wp = 1'b0;
    pins = 3'($random(seed));
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    wait_flag(1'b0);
    dev_rst = 1'b0;
    // Two clock rises clear the memory's link reset
    cmd(esb_pkg::OP_START, 8'h00, 1'b0);
    cmd(esb_pkg::OP_STOP, 8'h00, 1'b0);
    addr = 16'($random(seed)) | 16'h8000;
    do_write(addr, esb_pkg::FIFO_DEPTH + 1, 1'b0);
    repeat (20) @(negedge ref_clk);
    chk_byte("prog count", 8'h04, prog_count);
    chk_bit("prog busy", 1'b0, prog_busy);
    do_read(addr, esb_pkg::FIFO_DEPTH);
    wp = 1'b1;
    do_write(addr, 2, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk_byte("prog count", 8'h04, prog_count);
    wp = 1'b0;
    for (int k = 0; k < 2; k++) begin
      cmd(esb_pkg::OP_START, 8'h00, 1'b0);
      if (k == 0) begin
        wr({esb_pkg::DEV_TYPE ^ 4'h8, pins, 1'b0}, 1'b0);
      end else begin
        wr(sel_byte(pins ^ (3'($random(seed)) | 3'h1), 1'b0), 1'b0);
      end
      wr(8'($random(seed)), 1'b0);
      cmd(esb_pkg::OP_STOP, 8'h00, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
